// File: hdl/gpbc_pkg.sv
// constants and state type for the port b / port c pin-sharing block
`default_nettype none
package gpbc_pkg;
	localparam int          GPBC_W          = 16;
	localparam int          GPBC_NPHASE     = 6;
	localparam int          GPBC_NTMR       = 3;
	localparam int          GPBC_NIRQ       = 2;
	// register addresses
	localparam logic [15:0] GPBC_B_PIN      = 16'h7068;
	localparam logic [15:0] GPBC_B_LATCH    = 16'h7069;
	localparam logic [15:0] GPBC_B_DIR      = 16'h706a;
	localparam logic [15:0] GPBC_B_ATTR     = 16'h706b;
	localparam logic [15:0] GPBC_C_PIN      = 16'h7070;
	localparam logic [15:0] GPBC_C_LATCH    = 16'h7071;
	localparam logic [15:0] GPBC_C_DIR      = 16'h7072;
	localparam logic [15:0] GPBC_C_ATTR     = 16'h7073;
	localparam logic [15:0] GPBC_D_PIN      = 16'h7078;
	localparam logic [15:0] GPBC_B_SEL      = 16'h7081;
	localparam logic [15:0] GPBC_C_SEL      = 16'h7082;
	// reset values and writable-bit masks
	localparam logic [15:0] GPBC_RST_ZERO   = 16'h0000;
	localparam logic [15:0] GPBC_RST_ATTR   = 16'hffff;
	localparam logic [15:0] GPBC_RST_SEL_B  = 16'h003f;
	localparam logic [15:0] GPBC_RST_SEL_C  = 16'hfc00;
	localparam logic [15:0] GPBC_MASK_SEL_B = 16'h07ff;
	localparam logic [15:0] GPBC_MASK_SEL_C = 16'hffec;
	// port b pin positions
	localparam int          GPBC_B_SDO      = 13;
	localparam int          GPBC_B_SDI      = 12;
	localparam int          GPBC_B_SCK      = 11;
	localparam int          GPBC_B_TMR0     = 8;
	localparam int          GPBC_B_OVL1     = 7;
	localparam int          GPBC_B_FLT1     = 6;
	localparam int          GPBC_B_PHASE    = 0;
	// port c pin positions
	localparam int          GPBC_C_PHASE    = 10;
	localparam int          GPBC_C_FLT2     = 9;
	localparam int          GPBC_C_OVL2     = 8;
	localparam int          GPBC_C_TMR1     = 5;
	localparam int          GPBC_C_BUZ      = 4;
	localparam int          GPBC_C_IRQ      = 2;
	localparam int          GPBC_C_U2TX     = 1;
	localparam int          GPBC_C_U2RX     = 0;

	// whole state of the top module
	typedef struct packed {
		logic [15:0] b_sync1;
		logic [15:0] b_sync2;
		logic [15:0] c_sync1;
		logic [15:0] c_sync2;
		logic [15:0] latch_b;
		logic [15:0] latch_c;
		logic [15:0] dir_b;
		logic [15:0] dir_c;
		logic [15:0] attr_b;
		logic [15:0] attr_c;
		logic [15:0] sel_b;
		logic [15:0] sel_c;
		logic [15:0] rdata;
		logic [15:0] pb_out;
		logic [15:0] pb_oe;
		logic [15:0] pc_out;
		logic [15:0] pc_oe;
		logic        spi_din;
		logic        spi_sck;
		logic        uart1_rx;
		logic [2:0]  tmr0_cap;
		logic [2:0]  tmr1_cap;
		logic        ovl1;
		logic        flt1;
		logic        ovl2;
		logic        flt2;
		logic [1:0]  ext_irq;
		logic        uart2_rx;
	} gpbc_state_type;
endpackage : gpbc_pkg
`default_nettype wire

// File: hdl/gpbc_top.sv
// port b / port c gpio registers with peripheral pin sharing
//
// How it works
// - pin-level reads pads, latch reads latch
// - both data addresses write one latch
// - direction registers, reset all zeros
// - attribute registers, reset all ones
// - port b bits 10..8 give timer0 pins
// - port b bits 7,6 protection inputs
// - port b bits 5..0 select phase outputs
// - port b peripheral pin map
// - pin b13 spi data or uart1 transmit
// - pin b11 spi clock by master/slave
// - timer pin direction from direction register
// - port c bits 15..10 select phase outputs
// - port c bits 9,8 protection inputs
// - port c bits 7..5 give timer1 pins
// - port c bits 3,2 external interrupts
// - port c phases gated by float control
// - c0 uart2 receive gated, c1 transmit
// - full resets restore all register values
//
// Implementation choice: the plain strobed port.
`default_nettype none
module gpbc_top (
	// clock and reset
	input  wire  logic                    clk_in,
	input  wire  logic                    rst_n_in,
	// register port
	input  wire  logic [15:0]             addr_in,
	input  wire  logic [15:0]             wdata_in,
	input  wire  logic                    wr_in,
	input  wire  logic                    rd_in,
	output logic       [15:0]             rdata_out,
	// port b pads
	input  wire  logic [gpbc_pkg::GPBC_W-1:0] pb_pad_in,
	output logic       [gpbc_pkg::GPBC_W-1:0] pb_pad_out,
	output logic       [gpbc_pkg::GPBC_W-1:0] pb_pad_oe_out,
	output logic       [gpbc_pkg::GPBC_W-1:0] pb_attr_out,
	// port c pads
	input  wire  logic [gpbc_pkg::GPBC_W-1:0] pc_pad_in,
	output logic       [gpbc_pkg::GPBC_W-1:0] pc_pad_out,
	output logic       [gpbc_pkg::GPBC_W-1:0] pc_pad_oe_out,
	output logic       [gpbc_pkg::GPBC_W-1:0] pc_attr_out,
	// spi and uart1 side
	input  wire  logic                    spi_enable_in,
	input  wire  logic                    spi_master_in,
	input  wire  logic                    spi_dout_in,
	input  wire  logic                    spi_dout_out_disable_in,
	input  wire  logic                    spi_sck_in,
	input  wire  logic                    spi_clock_out_disable_in,
	input  wire  logic                    uart1_enable_in,
	input  wire  logic                    uart1_tx_in,
	input  wire  logic                    uart1_tx_out_disable_in,
	input  wire  logic                    uart1_rx_in_enable_in,
	output logic                          spi_din_out,
	output logic                          spi_sck_out,
	output logic                          uart1_rx_out,
	// timers
	input  wire  logic [2:0]              tmr0_pwm_in,
	input  wire  logic [2:0]              tmr1_pwm_in,
	input  wire  logic [5:0]              tmr3_phase_in,
	input  wire  logic                    timer3_outputs_float_in,
	input  wire  logic [5:0]              tmr4_phase_in,
	input  wire  logic                    timer4_outputs_float_in,
	output logic       [2:0]              tmr0_cap_out,
	output logic       [2:0]              tmr1_cap_out,
	output logic                          overload_pin1_out,
	output logic                          fault_input_pin1_out,
	output logic                          overload_pin2_out,
	output logic                          fault_input_pin2_out,
	// buzzer, interrupts, uart2
	input  wire  logic                    buzzer_pin_in,
	input  wire  logic                    buzzer_out_disable_in,
	input  wire  logic                    uart2_enable_in,
	input  wire  logic                    uart2_tx_pin_in,
	input  wire  logic                    uart2_tx_out_disable_in,
	input  wire  logic                    uart2_rx_in_enable_in,
	output logic       [1:0]              ext_irq_out,
	output logic                          uart2_rx_pin_out
);
	import gpbc_pkg::*;

	gpbc_state_type s;
	gpbc_state_type next_s;

	// next-state logic for the whole block
	always_comb begin
		next_s = s;
		// two-stage pad synchronisers
		next_s.b_sync1 = pb_pad_in;
		next_s.b_sync2 = s.b_sync1;
		next_s.c_sync1 = pc_pad_in;
		next_s.c_sync2 = s.c_sync1;

		// register writes
		if (wr_in) begin
			case (addr_in)
				// data and latch share a latch
				GPBC_B_PIN, GPBC_B_LATCH: begin
					next_s.latch_b = wdata_in;
				end
				GPBC_C_PIN, GPBC_C_LATCH: begin
					next_s.latch_c = wdata_in;
				end
				GPBC_B_DIR: begin
					next_s.dir_b = wdata_in;
				end
				GPBC_C_DIR: begin
					next_s.dir_c = wdata_in;
				end
				GPBC_B_ATTR: begin
					next_s.attr_b = wdata_in;
				end
				GPBC_C_ATTR: begin
					next_s.attr_c = wdata_in;
				end
				GPBC_B_SEL: begin
					next_s.sel_b = wdata_in & GPBC_MASK_SEL_B;
				end
				GPBC_C_SEL: begin
					next_s.sel_c = wdata_in & GPBC_MASK_SEL_C;
				end
				default: begin
				end
			endcase
		end

		// read data stands only the cycle after the strobe
		next_s.rdata = GPBC_RST_ZERO;
		if (rd_in) begin
			case (addr_in)
				GPBC_B_PIN:   next_s.rdata = s.b_sync2;
				GPBC_B_LATCH: next_s.rdata = s.latch_b;
				GPBC_B_DIR:   next_s.rdata = s.dir_b;
				GPBC_B_ATTR:  next_s.rdata = s.attr_b;
				GPBC_C_PIN:   next_s.rdata = s.c_sync2;
				GPBC_C_LATCH: next_s.rdata = s.latch_c;
				GPBC_C_DIR:   next_s.rdata = s.dir_c;
				GPBC_C_ATTR:  next_s.rdata = s.attr_c;
				GPBC_B_SEL:   next_s.rdata = s.sel_b;
				GPBC_C_SEL:   next_s.rdata = s.sel_c;
				default:      next_s.rdata = GPBC_RST_ZERO;
			endcase
		end

		// plain gpio by default: drive latch where direction is 1
		next_s.pb_out = s.latch_b;
		next_s.pb_oe  = s.dir_b;
		next_s.pc_out = s.latch_c;
		next_s.pc_oe  = s.dir_c;

		// b13 spi data out, else uart1 transmit
		if (spi_enable_in) begin
			next_s.pb_out[GPBC_B_SDO] = spi_dout_in;
			next_s.pb_oe[GPBC_B_SDO]  = !spi_dout_out_disable_in;
		end else if (uart1_enable_in) begin
			next_s.pb_out[GPBC_B_SDO] = uart1_tx_in;
			next_s.pb_oe[GPBC_B_SDO]  = !uart1_tx_out_disable_in;
		end
		// b12 is an input while spi or uart1 receive owns it
		next_s.spi_din  = s.b_sync2[GPBC_B_SDI];
		next_s.uart1_rx = uart1_rx_in_enable_in ? s.b_sync2[GPBC_B_SDI] : 1'b1;
		if (spi_enable_in || uart1_rx_in_enable_in) begin
			next_s.pb_oe[GPBC_B_SDI] = 1'b0;
		end
		// spi clock input as slave, output as master
		next_s.spi_sck = s.b_sync2[GPBC_B_SCK];
		if (spi_enable_in) begin
			next_s.pb_out[GPBC_B_SCK] = spi_sck_in;
			next_s.pb_oe[GPBC_B_SCK]  = spi_master_in && !spi_clock_out_disable_in;
		end
		for (int i = 0; i < GPBC_NTMR; i++) begin
			next_s.tmr0_cap[i] = s.b_sync2[GPBC_B_TMR0+i];
			if (s.sel_b[GPBC_B_TMR0+i]) begin
				// direction stays with the direction register
				next_s.pb_out[GPBC_B_TMR0+i] = tmr0_pwm_in[i];
				next_s.pb_oe[GPBC_B_TMR0+i]  = s.dir_b[GPBC_B_TMR0+i];
			end
		end
		// protection inputs, inactive low when not enabled
		next_s.ovl1 = s.sel_b[GPBC_B_OVL1] && s.b_sync2[GPBC_B_OVL1];
		next_s.flt1 = s.sel_b[GPBC_B_FLT1] && s.b_sync2[GPBC_B_FLT1];
		if (s.sel_b[GPBC_B_OVL1]) begin
			next_s.pb_oe[GPBC_B_OVL1] = 1'b0;
		end
		if (s.sel_b[GPBC_B_FLT1]) begin
			next_s.pb_oe[GPBC_B_FLT1] = 1'b0;
		end
		// timer3 phase outputs, floated as a group
		for (int i = 0; i < GPBC_NPHASE; i++) begin
			if (s.sel_b[GPBC_B_PHASE+i]) begin
				next_s.pb_out[GPBC_B_PHASE+i] = tmr3_phase_in[i];
				next_s.pb_oe[GPBC_B_PHASE+i]  = !timer3_outputs_float_in;
			end
		end

		for (int i = 0; i < GPBC_NPHASE; i++) begin
			if (s.sel_c[GPBC_C_PHASE+i]) begin
				next_s.pc_out[GPBC_C_PHASE+i] = tmr4_phase_in[i];
				next_s.pc_oe[GPBC_C_PHASE+i]  = !timer4_outputs_float_in;
			end
		end
		// protection inputs of the second bank
		next_s.flt2 = s.sel_c[GPBC_C_FLT2] && s.c_sync2[GPBC_C_FLT2];
		next_s.ovl2 = s.sel_c[GPBC_C_OVL2] && s.c_sync2[GPBC_C_OVL2];
		if (s.sel_c[GPBC_C_FLT2]) begin
			next_s.pc_oe[GPBC_C_FLT2] = 1'b0;
		end
		if (s.sel_c[GPBC_C_OVL2]) begin
			next_s.pc_oe[GPBC_C_OVL2] = 1'b0;
		end
		for (int i = 0; i < GPBC_NTMR; i++) begin
			next_s.tmr1_cap[i] = s.c_sync2[GPBC_C_TMR1+i];
			if (s.sel_c[GPBC_C_TMR1+i]) begin
				// direction stays with the direction register
				next_s.pc_out[GPBC_C_TMR1+i] = tmr1_pwm_in[i];
				next_s.pc_oe[GPBC_C_TMR1+i]  = s.dir_c[GPBC_C_TMR1+i];
			end
		end
		// buzzer has no select bit; its own disable hands the pin back
		if (!buzzer_out_disable_in) begin
			next_s.pc_out[GPBC_C_BUZ] = buzzer_pin_in;
			next_s.pc_oe[GPBC_C_BUZ]  = 1'b1;
		end
		for (int i = 0; i < GPBC_NIRQ; i++) begin
			next_s.ext_irq[i] = s.sel_c[GPBC_C_IRQ+i] && s.c_sync2[GPBC_C_IRQ+i];
			if (s.sel_c[GPBC_C_IRQ+i]) begin
				next_s.pc_oe[GPBC_C_IRQ+i] = 1'b0;
			end
		end
		if (uart2_enable_in) begin
			next_s.pc_out[GPBC_C_U2TX] = uart2_tx_pin_in;
			next_s.pc_oe[GPBC_C_U2TX]  = !uart2_tx_out_disable_in;
		end
		// idle-high receive line keeps the uart quiet while gated
		next_s.uart2_rx = uart2_rx_in_enable_in ? s.c_sync2[GPBC_C_U2RX] : 1'b1;
		if (uart2_rx_in_enable_in) begin
			next_s.pc_oe[GPBC_C_U2RX] = 1'b0;
		end

		// full reset; watchdog resets must not reach this pin
		if (!rst_n_in) begin
			next_s          = '0;
			next_s.attr_b   = GPBC_RST_ATTR;
			next_s.attr_c   = GPBC_RST_ATTR;
			next_s.sel_b    = GPBC_RST_SEL_B;
			next_s.sel_c    = GPBC_RST_SEL_C;
			next_s.uart1_rx = 1'b1;
			next_s.uart2_rx = 1'b1;
		end
	end

	// state register
	always_ff @(posedge clk_in) begin
		s <= next_s;
	end

	// outputs straight from the state
	assign rdata_out            = s.rdata;
	assign pb_pad_out           = s.pb_out;
	assign pb_pad_oe_out        = s.pb_oe;
	assign pb_attr_out          = s.attr_b;
	assign pc_pad_out           = s.pc_out;
	assign pc_pad_oe_out        = s.pc_oe;
	assign pc_attr_out          = s.attr_c;
	assign spi_din_out          = s.spi_din;
	assign spi_sck_out          = s.spi_sck;
	assign uart1_rx_out         = s.uart1_rx;
	assign tmr0_cap_out         = s.tmr0_cap;
	assign tmr1_cap_out         = s.tmr1_cap;
	assign overload_pin1_out    = s.ovl1;
	assign fault_input_pin1_out = s.flt1;
	assign overload_pin2_out    = s.ovl2;
	assign fault_input_pin2_out = s.flt2;
	assign ext_irq_out          = s.ext_irq;
	assign uart2_rx_pin_out     = s.uart2_rx;

	// checks on the block's own behaviour
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence s_wr_pin_b;
		wr_in && addr_in == GPBC_B_PIN;
	endsequence
	sequence s_rd_pin_c;
		rd_in && addr_in == GPBC_C_PIN;
	endsequence

	a_pin_write_alias: assert property (
		s_wr_pin_b |=> rdata_out == GPBC_RST_ZERO ##0 s.latch_b == $past(wdata_in))
		else $error("pin-level write did not reach latch");
	a_pad_read_path: assert property (
		s_rd_pin_c |=> rdata_out == $past(pc_pad_in, 3))
		else $error("pin-level read not from pad");
	a_latch_read_path: assert property (
		rd_in && addr_in == GPBC_B_LATCH |=> rdata_out == $past(s.latch_b))
		else $error("latch read wrong");
	a_reset_values: assert property (
		disable iff (1'b0) !rst_n_in |=> s.dir_b == GPBC_RST_ZERO && s.attr_c == GPBC_RST_ATTR
		&& s.sel_b == GPBC_RST_SEL_B && s.sel_c == GPBC_RST_SEL_C && s.latch_c == GPBC_RST_ZERO)
		else $error("reset values wrong");
	a_rsvd_zero: assert property (
		(s.sel_b & ~GPBC_MASK_SEL_B) == GPBC_RST_ZERO && (s.sel_c & ~GPBC_MASK_SEL_C) == GPBC_RST_ZERO)
		else $error("reserved select bit set");
	a_phase_float: assert property (
		s.sel_c[GPBC_C_PHASE] && timer4_outputs_float_in |=> !pc_pad_oe_out[GPBC_C_PHASE])
		else $error("phase output not floated");
	a_phase_drive: assert property (
		s.sel_b[GPBC_B_PHASE] && !timer3_outputs_float_in |=>
		pb_pad_oe_out[GPBC_B_PHASE] && pb_pad_out[GPBC_B_PHASE] == $past(tmr3_phase_in[0]))
		else $error("phase output not driven");
	a_timer_dir: assert property (
		s.sel_b[GPBC_B_TMR0] |=> pb_pad_oe_out[GPBC_B_TMR0] == $past(s.dir_b[GPBC_B_TMR0]))
		else $error("timer pin direction wrong");
	a_sck_slave: assert property (
		spi_enable_in && !spi_master_in |=> !pb_pad_oe_out[GPBC_B_SCK])
		else $error("slave clock pin driven");
	a_uart2_rx_gate: assert property (
		!uart2_rx_in_enable_in |=> uart2_rx_pin_out)
		else $error("uart2 receive not gated");
	a_uart1_float: assert property (
		!spi_enable_in && uart1_enable_in && uart1_tx_out_disable_in |=> !pb_pad_oe_out[GPBC_B_SDO])
		else $error("uart1 transmit not floated");
	a_irq_follow: assert property (
		s.sel_c[GPBC_C_IRQ] |-> ##2 ext_irq_out[0] == $past(s.c_sync2[GPBC_C_IRQ]) || !$past(s.sel_c[GPBC_C_IRQ]))
		else $error("interrupt input not passed");

	// register landing, gating and pin ownership checks
	sequence s_wr_attr_c;
		wr_in && addr_in == GPBC_C_ATTR;
	endsequence
	sequence s_wr_dir_b;
		wr_in && addr_in == GPBC_B_DIR;
	endsequence
	a_read_idle: assert property (
		!rd_in |=> rdata_out == GPBC_RST_ZERO)
		else $error("read data outside its cycle");
	a_dir_write: assert property (
		s_wr_dir_b |=> s.dir_b == $past(wdata_in))
		else $error("direction write lost");
	a_attr_write: assert property (
		s_wr_attr_c |=> pc_attr_out == $past(wdata_in))
		else $error("attribute write lost");
	a_timer0_out: assert property (
		s.sel_b[GPBC_B_TMR0+2] |=> pb_pad_out[GPBC_B_TMR0+2] == $past(tmr0_pwm_in[2]))
		else $error("timer0 output not passed");
	a_ovl1_gate: assert property (
		!s.sel_b[GPBC_B_OVL1] |=> !overload_pin1_out)
		else $error("overload input 1 not gated");
	a_spi_sdo: assert property (
		spi_enable_in && !spi_dout_out_disable_in |=> pb_pad_oe_out[GPBC_B_SDO]
		&& pb_pad_out[GPBC_B_SDO] == $past(spi_dout_in))
		else $error("spi data output not driven");
	a_phase_c_drive: assert property (
		s.sel_c[GPBC_C_PHASE] && !timer4_outputs_float_in |=> pc_pad_oe_out[GPBC_C_PHASE]
		&& pc_pad_out[GPBC_C_PHASE] == $past(tmr4_phase_in[0]))
		else $error("second bank phase not driven");
	a_flt2_gate: assert property (
		!s.sel_c[GPBC_C_FLT2] |=> !fault_input_pin2_out)
		else $error("fault input 2 not gated");
	a_timer1_pin: assert property (
		s.sel_c[GPBC_C_TMR1+2] |=> pc_pad_out[GPBC_C_TMR1+2] == $past(tmr1_pwm_in[2])
		&& pc_pad_oe_out[GPBC_C_TMR1+2] == $past(s.dir_c[GPBC_C_TMR1+2]))
		else $error("timer1 pin wrong");
	a_irq1_gate: assert property (
		!s.sel_c[GPBC_C_IRQ+1] |=> !ext_irq_out[1])
		else $error("interrupt input 1 not gated");
	a_buzzer_drive: assert property (
		!buzzer_out_disable_in |=> pc_pad_oe_out[GPBC_C_BUZ]
		&& pc_pad_out[GPBC_C_BUZ] == $past(buzzer_pin_in))
		else $error("buzzer pin not driven");
	a_uart2_float: assert property (
		uart2_enable_in && uart2_tx_out_disable_in |=> !pc_pad_oe_out[GPBC_C_U2TX])
		else $error("uart2 transmit not floated");
endmodule : gpbc_top
`default_nettype wire

// File: testbench/gpbc_pad_model.sv
// pad-side model: resolves each pad from chip drive, outside drive and pull level
`default_nettype none
module gpbc_pad_model (
	// chip side of the pads
	input  wire logic [15:0] pad_out_in,
	input  wire logic [15:0] pad_oe_in,
	input  wire logic [15:0] pad_attr_in,
	// outside circuitry
	input  wire logic [15:0] ext_level_in,
	input  wire logic [15:0] ext_drive_in,
	// level seen at the pad
	output logic      [15:0] pad_level_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// released pads fall to the pull level, never keep the last driven value
	assign pad_level_out = (pad_oe_in & pad_out_in) | (~pad_oe_in & ext_drive_in & ext_level_in)
		| (~pad_oe_in & ~ext_drive_in & pad_attr_in);
endmodule : gpbc_pad_model
`default_nettype wire

// File: testbench/tb_top.sv
// self-checking bench for the port b / port c pin-sharing block
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import gpbc_pkg::*;
	// clock, reset and register port
	logic        clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic [15:0] addr_in = 16'h0000;
	logic [15:0] wdata_in = 16'h0000;
	logic        wr_in = 1'b0;
	logic        rd_in = 1'b0;
	logic [15:0] rdata_out;
	// pads and outside drive
	logic [15:0] pb_pad_in, pb_pad_out, pb_pad_oe_out, pb_attr_out;
	logic [15:0] pc_pad_in, pc_pad_out, pc_pad_oe_out, pc_attr_out;
	logic [15:0] pb_ext = 16'h0000;
	logic [15:0] pb_drv = 16'hffff;
	logic [15:0] pc_ext = 16'h0000;
	logic [15:0] pc_drv = 16'hffff;
	// peripheral side
	logic spi_enable_in = 1'b0, spi_master_in = 1'b0, spi_dout_in = 1'b0;
	logic spi_dout_out_disable_in = 1'b0, spi_sck_in = 1'b0, spi_clock_out_disable_in = 1'b0;
	logic uart1_enable_in = 1'b0, uart1_tx_in = 1'b0, uart1_tx_out_disable_in = 1'b0;
	logic uart1_rx_in_enable_in = 1'b0, buzzer_pin_in = 1'b0, buzzer_out_disable_in = 1'b1;
	logic uart2_enable_in = 1'b0, uart2_tx_pin_in = 1'b0, uart2_tx_out_disable_in = 1'b0;
	logic uart2_rx_in_enable_in = 1'b0, timer3_outputs_float_in = 1'b0;
	logic timer4_outputs_float_in = 1'b0;
	logic [2:0] tmr0_pwm_in = 3'h0, tmr1_pwm_in = 3'h0;
	logic [5:0] tmr3_phase_in = 6'h00, tmr4_phase_in = 6'h00;
	logic spi_din_out, spi_sck_out, uart1_rx_out, overload_pin1_out, fault_input_pin1_out;
	logic overload_pin2_out, fault_input_pin2_out, uart2_rx_pin_out;
	logic [2:0] tmr0_cap_out, tmr1_cap_out;
	logic [1:0] ext_irq_out;
	int fail_count = 0;
	int samples_checked = 0;
	int cycles = 0;

	gpbc_top dut_u (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
		.pb_pad_in, .pb_pad_out, .pb_pad_oe_out, .pb_attr_out,
		.pc_pad_in, .pc_pad_out, .pc_pad_oe_out, .pc_attr_out,
		.spi_enable_in, .spi_master_in, .spi_dout_in, .spi_dout_out_disable_in, .spi_sck_in,
		.spi_clock_out_disable_in, .uart1_enable_in, .uart1_tx_in, .uart1_tx_out_disable_in,
		.uart1_rx_in_enable_in, .spi_din_out, .spi_sck_out, .uart1_rx_out,
		.tmr0_pwm_in, .tmr1_pwm_in, .tmr3_phase_in, .timer3_outputs_float_in, .tmr4_phase_in,
		.timer4_outputs_float_in, .tmr0_cap_out, .tmr1_cap_out, .overload_pin1_out,
		.fault_input_pin1_out, .overload_pin2_out, .fault_input_pin2_out,
		.buzzer_pin_in, .buzzer_out_disable_in, .uart2_enable_in, .uart2_tx_pin_in,
		.uart2_tx_out_disable_in, .uart2_rx_in_enable_in, .ext_irq_out, .uart2_rx_pin_out);
	gpbc_pad_model pad_b_u (.pad_out_in(pb_pad_out), .pad_oe_in(pb_pad_oe_out),
		.pad_attr_in(pb_attr_out), .ext_level_in(pb_ext), .ext_drive_in(pb_drv),
		.pad_level_out(pb_pad_in));
	gpbc_pad_model pad_c_u (.pad_out_in(pc_pad_out), .pad_oe_in(pc_pad_oe_out),
		.pad_attr_in(pc_attr_out), .ext_level_in(pc_ext), .ext_drive_in(pc_drv),
		.pad_level_out(pc_pad_in));

	// 25 ns clock
	always #12.5 clk_in = ~clk_in;

	// hang guard: the whole run needs well under this many cycles
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			finish_test();
		end
	end

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// one-cycle write strobe, signals change just after an edge
	task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask : reg_wr

	// read data stands only in the cycle after the strobe
	task automatic reg_rd(input logic [15:0] a, input logic [15:0] exp, input string what);
		@(posedge clk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		chk(what, exp, rdata_out);
	endtask : reg_rd

	// pad inputs pass three flops, so settle waits cover that
	task automatic settle(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : settle

	// reset values of every register, plus an unmapped address
	task automatic reset_values();
		logic [15:0] ra [9] = '{GPBC_B_LATCH, GPBC_B_DIR, GPBC_B_ATTR, GPBC_C_LATCH,
			GPBC_C_DIR, GPBC_C_ATTR, GPBC_B_SEL, GPBC_C_SEL, GPBC_D_PIN};
		logic [15:0] rv [9] = '{16'h0000, 16'h0000, 16'hffff, 16'h0000, 16'h0000, 16'hffff,
			16'h003f, 16'hfc00, 16'h0000};
		for (int i = 0; i < 9; i++) begin
			reg_rd(ra[i], rv[i], "reset value");
		end
		chk("attr pins", 16'hffff, pb_attr_out & pc_attr_out);
		$display("test reset values done");
	endtask : reset_values

	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test

	initial begin
		logic [15:0] base;
		logic [15:0] po;
		repeat (4) @(posedge clk_in);
		rst_n_in <= 1'b1;
		reset_values();
		// plain gpio on both ports: pin read, latch read, shared write
		pb_ext <= 16'ha5c3;
		pc_ext <= 16'h3c5a;
		reg_wr(GPBC_B_SEL, 16'h0000);
		reg_wr(GPBC_C_SEL, 16'h0000);
		for (int p = 0; p < 2; p++) begin
			base = p ? GPBC_C_PIN : GPBC_B_PIN;
			reg_wr(base, 16'h1234);
			reg_rd(base + 16'h0001, 16'h1234, "latch via pin addr");
			settle(4);
			reg_rd(base, p ? 16'h3c5a : 16'ha5c3, "pad level");
			reg_wr(base + 16'h0001, 16'h4321);
			reg_rd(base + 16'h0002, 16'h0000, "dir unchanged");
			reg_wr(base + 16'h0002, 16'hffff);
			reg_wr(base + 16'h0003, 16'h0f0f);
			reg_rd(base + 16'h0003, 16'h0f0f, "attr");
			// modify one bit through the latch address, never the pin address
			reg_rd(base + 16'h0001, 16'h4321, "latch read");
			reg_wr(base + 16'h0001, 16'h4321 | 16'h0008);
			settle(2);
			po = p ? pc_pad_out : pb_pad_out;
			chk("gpio drive", 16'h4329, po);
		end
		pb_drv <= 16'h0000;
		pc_drv <= 16'h0000;
		settle(5);
		reg_rd(GPBC_B_PIN, 16'h4329, "driven pad level");
		$display("test gpio data done");
		// reserved select bits, then port b and port c sharing
		reg_wr(GPBC_B_SEL, 16'hffff);
		reg_rd(GPBC_B_SEL, 16'h07ff, "b select mask");
		reg_wr(GPBC_C_SEL, 16'hffff);
		reg_rd(GPBC_C_SEL, 16'hffec, "c select mask");
		reg_wr(GPBC_B_DIR, 16'h0400);
		reg_wr(GPBC_C_DIR, 16'h0080);
		pb_drv <= 16'h03c0;
		pb_ext <= 16'h0180;
		pc_drv <= 16'h030d;
		pc_ext <= 16'h0208;
		tmr3_phase_in <= 6'h2a;
		tmr4_phase_in <= 6'h15;
		tmr0_pwm_in <= 3'h5;
		tmr1_pwm_in <= 3'h4;
		settle(5);
		chk("b phase out", 16'h002a, pb_pad_out & 16'h003f);
		chk("b oe", 16'h043f, pb_pad_oe_out & 16'h07ff);
		chk("b timer out", 16'h0500, pb_pad_out & 16'h0700);
		chk("timer0 capture", 16'(3'h5), 16'(tmr0_cap_out));
		chk("b protection", 16'(2'h2), 16'({overload_pin1_out, fault_input_pin1_out}));
		chk("c phase out", 16'h5400, pc_pad_out & 16'hfc00);
		chk("c oe", 16'hfc80, pc_pad_oe_out & 16'hffec);
		chk("c timer out", 16'h0080, pc_pad_out & 16'h00e0);
		chk("timer1 capture", 16'(3'h4), 16'(tmr1_cap_out));
		chk("c protection", 16'(2'h1), 16'({overload_pin2_out, fault_input_pin2_out}));
		chk("ext irq", 16'(2'h2), 16'(ext_irq_out));
		timer3_outputs_float_in <= 1'b1;
		timer4_outputs_float_in <= 1'b1;
		settle(2);
		chk("b phase float", 16'h0000, pb_pad_oe_out & 16'h003f);
		chk("c phase float", 16'h0000, pc_pad_oe_out & 16'hfc00);
		reg_wr(GPBC_C_SEL, 16'h0000);
		settle(5);
		chk("irq off", 16'(2'h0), 16'(ext_irq_out));
		$display("test pin sharing done");
		// serial, buzzer and second uart pins
		uart1_enable_in <= 1'b1;
		uart1_tx_in <= 1'b1;
		buzzer_out_disable_in <= 1'b0;
		buzzer_pin_in <= 1'b1;
		uart2_enable_in <= 1'b1;
		uart2_tx_pin_in <= 1'b1;
		uart2_rx_in_enable_in <= 1'b1;
		uart1_rx_in_enable_in <= 1'b1;
		settle(5);
		chk("uart1 tx", 16'h2000, pb_pad_out & pb_pad_oe_out & 16'h2000);
		chk("buzzer", 16'h0010, pc_pad_out & pc_pad_oe_out & 16'h0010);
		chk("uart2 tx", 16'h0002, pc_pad_out & pc_pad_oe_out & 16'h0002);
		chk("uart2 rx", 16'(1'b0), 16'(uart2_rx_pin_out));
		chk("uart1 rx", 16'(1'b0), 16'(uart1_rx_out));
		uart1_tx_out_disable_in <= 1'b1;
		uart2_tx_out_disable_in <= 1'b1;
		uart2_rx_in_enable_in <= 1'b0;
		settle(5);
		chk("uart2 tx off", 16'h0000, pc_pad_oe_out & 16'h0002);
		chk("uart2 rx off", 16'(1'b1), 16'(uart2_rx_pin_out));
		chk("uart1 tx off", 16'h0000, pb_pad_oe_out & 16'h2000);
		spi_enable_in <= 1'b1;
		spi_master_in <= 1'b1;
		spi_sck_in <= 1'b1;
		settle(5);
		chk("spi master", 16'h2800, pb_pad_oe_out & 16'h2800);
		chk("spi sck", 16'h0800, pb_pad_out & 16'h2800);
		spi_master_in <= 1'b0;
		// b11 held low outside, so a chip still driving it shows as a one
		pb_drv <= 16'h1800;
		pb_ext <= 16'h1000;
		settle(5);
		chk("spi slave", 16'h0000, pb_pad_oe_out & 16'h0800);
		chk("sck in", 16'(1'b0), 16'(spi_sck_out));
		chk("spi data in", 16'(1'b1), 16'(spi_din_out));
		$display("test serial pins done");
		// reset in mid-run brings every register back
		rst_n_in <= 1'b0;
		settle(2);
		rst_n_in <= 1'b1;
		reset_values();
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
